// file: hdl/wdc_pkg.sv
package wdc_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;

	// Register select codes
	typedef enum logic [2:0] {
		WDC_SEL_CONTROL = 3'h0,
		WDC_SEL_IRQ_STAT = 3'h1,
		WDC_SEL_IRQ_MASK = 3'h2,
		WDC_SEL_COUNT = 3'h3,
		WDC_SEL_NONE = 3'h4
	} wdc_sel_t;

	// Control register field positions
	localparam int BIT_UNLOCK = 0;
	localparam int BIT_ENABLE = 1;
	localparam int BIT_STATUS = 2;
	localparam int BIT_RSEL = 3;
	localparam int PRE_LSB = 4;
	localparam int PRE_MSB = 7;

	// Interrupt status bit positions
	localparam int IRQ_TIMEOUT = 0;
	localparam int IRQ_REFUSED = 1;
	localparam int IRQ_BITS = 2;

	// Reset values and counter shape
	localparam logic [3:0] PRE_RESET = 4'h7;
	localparam logic [3:0] PRE_MAX = 4'h7;
	localparam logic [4:0] PRE_BASE = 5'h09;
	localparam logic ENABLE_RESET = 1'b1;
	localparam logic RSEL_RESET = 1'b0;
	localparam int COUNT_W = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hdl/wdc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for inputs from outside the clock domain
module wdc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// file: hdl/wdc_top.sv
// What this block does
// [R1] A timeout of the counter sets the timeout status flag in bit 2.
// [R2] The status flag resets to 0 and clears only on a written zero or reset.
// [R3] The block's own timeout reset leaves the status flag set.
// [R4] The enable bit in bit 1 resets to 1, so the counter runs from reset.
// [R5] Setting the enable bit enables the counter and clears it to zero.
// [R6] Every later unlocked write that sets the enable bit clears the counter again.
// [R7] A timeout without a clear raises a reset or an interrupt.
// [R8] Zero write, timeout reset, supply or lock disable it; hardware reset sets it.
// [R9] A control write lands only right after the unlock bit was set.
// [R10] A control write not right after the unlock is dropped; the unlock then ends.
// [R11] Software masks interrupts around the unlock-and-write pair.
// [R12] Response select 0 gives a reset on timeout, 1 gives an interrupt.
// [R13] The 16-bit counter runs on the 32 kHz clock, period 2^pre x 512, pre codes above 7 taken as 7.
`timescale 1ns/1ps
`default_nettype none
module wdc_top (
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        CLK32K_IN,
	input  wire logic        SUPPLY_IRQ_IN,
	input  wire logic        LOCK_IRQ_IN,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output var  logic        S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output var  logic        S_AXI_WREADY,
	output var  logic [1:0]  S_AXI_BRESP,
	output var  logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output var  logic        S_AXI_ARREADY,
	output var  logic [31:0] S_AXI_RDATA,
	output var  logic [1:0]  S_AXI_RRESP,
	output var  logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output var  logic        DOG_RESET,
	output var  logic        DOG_IRQ
);
	////////////////////////////////////////////////////////////////////////
	// Functions

	// Address to register select
	function automatic wdc_pkg::wdc_sel_t reg_sel(input logic [7:0] a);
		logic [7:0] w;
		w = {a[7:2], 2'b00};
		if (w == wdc_pkg::OFF_CONTROL)
			return wdc_pkg::WDC_SEL_CONTROL;
		else if (w == wdc_pkg::OFF_IRQ_STAT)
			return wdc_pkg::WDC_SEL_IRQ_STAT;
		else if (w == wdc_pkg::OFF_IRQ_MASK)
			return wdc_pkg::WDC_SEL_IRQ_MASK;
		else if (w == wdc_pkg::OFF_COUNT)
			return wdc_pkg::WDC_SEL_COUNT;
		else
			return wdc_pkg::WDC_SEL_NONE;
	endfunction

	// Terminal count 2^(pre+9)-1, codes above 7 held at 7
	function automatic logic [15:0] term_count(input logic [3:0] p);
		logic [3:0]  ps;
		logic [16:0] one;
		ps = (p > wdc_pkg::PRE_MAX) ? wdc_pkg::PRE_MAX : p;
		one = 17'h00001 << ({1'b0, ps} + wdc_pkg::PRE_BASE);
		return 16'((one - 17'h00001) & 17'h0ffff);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [2:0] sync_q;
	logic       clk32_prev_reg;
	logic       tick;
	logic       supply_s;
	logic       lock_s;

	wdc_sync #(.W(3)) u_sync (
		.clk   (CLK),
		.rst_n (RESETN),
		.d     ({LOCK_IRQ_IN, SUPPLY_IRQ_IN, CLK32K_IN}),
		.q     (sync_q)
	);

	// Rising edge of the slow clock as a one-cycle enable
	assign tick = sync_q[0] & ~clk32_prev_reg;
	assign supply_s = sync_q[1];
	assign lock_s = sync_q[2];

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	logic        aw_have_reg, aw_have_next;
	logic [7:0]  aw_addr_reg, aw_addr_next;
	logic        w_have_reg, w_have_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0]  w_strb_reg, w_strb_next;
	logic        awready_reg, awready_next;
	logic        wready_reg, wready_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        arready_reg, arready_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic        wr_fire;
	wdc_pkg::wdc_sel_t wr_sel;
	wdc_pkg::wdc_sel_t rd_sel;

	// Core state read by the bus, and the DOG_RESET and DOG_IRQ flops
	logic [3:0]  pre_reg, pre_next;
	logic        rsel_reg, rsel_next;
	logic        status_reg, status_next;
	logic        enable_reg, enable_next;
	logic        armed_reg, armed_next;
	logic [15:0] count_reg, count_next;
	logic [wdc_pkg::IRQ_BITS-1:0] istat_reg, istat_next;
	logic [wdc_pkg::IRQ_BITS-1:0] imask_reg, imask_next;
	logic        dog_reset_reg, dog_reset_next;
	logic        dog_irq_reg, dog_irq_next;

	// Write happens once address and data are both held and no write response is pending
	assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
	assign wr_sel = reg_sel(aw_addr_reg);
	assign rd_sel = reg_sel(S_AXI_ARADDR);

	// Bus channel next state
	always_comb begin
		aw_have_next = aw_have_reg;
		aw_addr_next = aw_addr_reg;
		w_have_next = w_have_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (S_AXI_AWVALID && awready_reg) begin
			aw_have_next = 1'b1;
			aw_addr_next = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && wready_reg) begin
			w_have_next = 1'b1;
			w_data_next = S_AXI_WDATA;
			w_strb_next = S_AXI_WSTRB;
		end
		if (bvalid_reg && S_AXI_BREADY)
			bvalid_next = 1'b0;
		if (wr_fire) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (wr_sel == wdc_pkg::WDC_SEL_NONE) ?
				wdc_pkg::RESP_SLVERR : wdc_pkg::RESP_OKAY;
		end
		if (rvalid_reg && S_AXI_RREADY)
			rvalid_next = 1'b0;
		if (S_AXI_ARVALID && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = wdc_pkg::RESP_OKAY;
			rdata_next = '0;
			unique case (rd_sel)
				wdc_pkg::WDC_SEL_CONTROL: begin
					rdata_next[wdc_pkg::PRE_MSB:wdc_pkg::PRE_LSB] = pre_reg;
					rdata_next[wdc_pkg::BIT_RSEL] = rsel_reg;
					rdata_next[wdc_pkg::BIT_STATUS] = status_reg;
					rdata_next[wdc_pkg::BIT_ENABLE] = enable_reg;
					rdata_next[wdc_pkg::BIT_UNLOCK] = armed_reg;
				end
				wdc_pkg::WDC_SEL_IRQ_STAT:
					rdata_next[wdc_pkg::IRQ_BITS-1:0] = istat_reg;
				wdc_pkg::WDC_SEL_IRQ_MASK:
					rdata_next[wdc_pkg::IRQ_BITS-1:0] = imask_reg;
				wdc_pkg::WDC_SEL_COUNT:
					rdata_next[wdc_pkg::COUNT_W-1:0] = count_reg;
				default:
					rresp_next = wdc_pkg::RESP_SLVERR;
			endcase
		end
		awready_next = ~aw_have_next;
		wready_next = ~w_have_next;
		arready_next = ~rvalid_next;
	end

	// Bus channel registers
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= wdc_pkg::RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= wdc_pkg::RESP_OKAY;
		end else begin
			aw_have_reg <= aw_have_next;
			aw_addr_reg <= aw_addr_next;
			w_have_reg <= w_have_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog core

	logic ctrl_wr;
	logic apply;
	logic refused;
	logic kick;
	logic timeout;
	logic [wdc_pkg::IRQ_BITS-1:0] w1c;
	logic [wdc_pkg::IRQ_BITS-1:0] events;

	assign ctrl_wr = wr_fire & (wr_sel == wdc_pkg::WDC_SEL_CONTROL) &
		w_strb_reg[0];
	assign apply = ctrl_wr & armed_reg; // R9
	assign refused = ctrl_wr & ~armed_reg &
		~w_data_reg[wdc_pkg::BIT_UNLOCK]; // R10
	assign kick = apply & w_data_reg[wdc_pkg::BIT_ENABLE]; // R5 R6
	assign timeout = enable_reg & tick & ~kick &
		(count_reg == term_count(pre_reg)); // R13

	// Next values of control, counter and interrupt state
	always_comb begin
		pre_next = pre_reg;
		rsel_next = rsel_reg;
		status_next = status_reg;
		enable_next = enable_reg;
		armed_next = armed_reg;
		count_next = count_reg;
		// Unlock lasts for the one following write
		if (wr_fire) begin
			if (armed_reg)
				armed_next = 1'b0; // R10
			else if (ctrl_wr && w_data_reg[wdc_pkg::BIT_UNLOCK])
				armed_next = 1'b1; // R9
		end
		if (apply) begin
			pre_next = w_data_reg[wdc_pkg::PRE_MSB:wdc_pkg::PRE_LSB];
			rsel_next = w_data_reg[wdc_pkg::BIT_RSEL];
			enable_next = w_data_reg[wdc_pkg::BIT_ENABLE]; // R5 R8
			if (!w_data_reg[wdc_pkg::BIT_STATUS])
				status_next = 1'b0; // R2
		end
		// Counting on the slow clock edge
		if (kick)
			count_next = 16'h0000; // R5 R6
		else if (enable_reg && tick)
			count_next = timeout ? 16'h0000 : count_reg + 16'h0001; // R13
		// Timeout sets status over any clear, reset keeps it
		if (timeout) begin
			status_next = 1'b1; // R1 R3
			if (!rsel_reg)
				enable_next = 1'b0; // R8 R12
		end
		if (supply_s || lock_s)
			enable_next = 1'b0; // R8
		dog_reset_next = timeout & ~rsel_reg; // R7 R12
		events = '0;
		events[wdc_pkg::IRQ_TIMEOUT] = timeout & rsel_reg; // R7 R12
		events[wdc_pkg::IRQ_REFUSED] = refused;
		w1c = '0;
		if (wr_fire && w_strb_reg[0] &&
				wr_sel == wdc_pkg::WDC_SEL_IRQ_STAT)
			w1c = w_data_reg[wdc_pkg::IRQ_BITS-1:0];
		imask_next = imask_reg;
		if (wr_fire && w_strb_reg[0] &&
				wr_sel == wdc_pkg::WDC_SEL_IRQ_MASK)
			imask_next = w_data_reg[wdc_pkg::IRQ_BITS-1:0];
		istat_next = (istat_reg & ~w1c) | events;
		dog_irq_next = |(istat_next & imask_next);
	end

	// Core registers, hardware reset clears status and sets enable
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			clk32_prev_reg <= 1'b0;
			pre_reg <= wdc_pkg::PRE_RESET; // R13
			rsel_reg <= wdc_pkg::RSEL_RESET;
			status_reg <= 1'b0; // R2
			enable_reg <= wdc_pkg::ENABLE_RESET; // R4
			armed_reg <= 1'b0;
			count_reg <= 16'h0000;
			istat_reg <= '0;
			imask_reg <= '0;
			dog_reset_reg <= 1'b0;
			dog_irq_reg <= 1'b0;
		end else begin
			clk32_prev_reg <= sync_q[0];
			pre_reg <= pre_next;
			rsel_reg <= rsel_next;
			status_reg <= status_next;
			enable_reg <= enable_next;
			armed_reg <= armed_next;
			count_reg <= count_next;
			istat_reg <= istat_next;
			imask_reg <= imask_next;
			dog_reset_reg <= dog_reset_next;
			dog_irq_reg <= dog_irq_next;
		end
	end

	// Outputs straight from flops
	assign S_AXI_AWREADY = awready_reg;
	assign S_AXI_WREADY = wready_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;
	assign S_AXI_ARREADY = arready_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
	assign DOG_RESET = dog_reset_reg;
	assign DOG_IRQ = dog_irq_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	status_set_a: assert property (timeout |=> status_reg) // R1
		else $error("status not set after timeout");
	status_hold_a: assert property ( // R2
		status_reg && !(apply && !w_data_reg[wdc_pkg::BIT_STATUS])
		|=> status_reg)
		else $error("status cleared without a zero write");
	reset_keeps_a: assert property ( // R3
		dog_reset_reg |-> status_reg && !enable_reg)
		else $error("timeout reset lost status or left enable set");
	kick_clear_a: assert property (kick |=> count_reg == 16'h0000) // R6
		else $error("enable write did not clear counter");
	resp_reset_a: assert property ( // R12
		timeout && !rsel_reg |=> DOG_RESET ##1 !DOG_RESET)
		else $error("reset response missing or too long");
	resp_irq_a: assert property ( // R7
		timeout && rsel_reg |=> istat_reg[wdc_pkg::IRQ_TIMEOUT] &&
		!DOG_RESET &&
		(enable_reg || $past(supply_s || lock_s || apply)))
		else $error("interrupt response wrong");
	event_off_a: assert property ((supply_s || lock_s) |=> !enable_reg) // R8
		else $error("enable stays set after disable event");
	unlock_once_a: assert property ( // R10
		wr_fire && armed_reg |=> !armed_reg)
		else $error("unlock outlived one write");
	locked_write_a: assert property ( // R9
		ctrl_wr && !armed_reg |=> $stable(pre_reg) && $stable(rsel_reg) &&
		($past(supply_s || lock_s || timeout) || $stable(enable_reg)))
		else $error("locked control write took effect");
	count_step_a: assert property ( // R13
		enable_reg && tick && !kick && !timeout
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("counter did not step on slow tick");
	irq_out_a: assert property (
		DOG_IRQ == |(istat_reg & imask_reg))
		else $error("interrupt output does not match status");
	bus_order_a: assert property (
		wr_fire |=> S_AXI_BVALID && !aw_have_reg && !w_have_reg)
		else $error("write response not raised after write");
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        CLK, RESETN, SUPPLY_IRQ_IN, LOCK_IRQ_IN;
	wire logic   CLK32K_IN;
	logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0]  S_AXI_WSTRB;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic        S_AXI_RVALID, S_AXI_RREADY, DOG_RESET, DOG_IRQ;
	logic [2:0]  slow_cnt = 3'h0;
	int          fails, comparisons, cycles, resets;
	logic [31:0] rd;
	logic [1:0]  rr;

	wdc_top wdc_top_inst (.CLK(CLK), .RESETN(RESETN), .CLK32K_IN(CLK32K_IN),
		.SUPPLY_IRQ_IN(SUPPLY_IRQ_IN), .LOCK_IRQ_IN(LOCK_IRQ_IN),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY), .DOG_RESET(DOG_RESET),
		.DOG_IRQ(DOG_IRQ));

	////////////////////////////////////////////////////////////////////////
	// Clock, slow tick source, reset pulse counter and hang guard
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	assign CLK32K_IN = slow_cnt[2]; // Slow clock at one eighth of CLK
	always @(posedge CLK) begin
		slow_cnt <= slow_cnt + 3'h1;
		if (DOG_RESET === 1'b1)
			resets++;
		cycles++;
		if (cycles == 30000) begin
			fails++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared checks and bus cycles
	task automatic print_verdict();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Each channel held until its handshake edge, seen one half cycle ahead
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit aw, w, b;
		int n;
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		b = 0;
		n = 0;
		while (!b && n < 200) begin
			@(negedge CLK);
			aw = S_AXI_AWVALID && (S_AXI_AWREADY === 1'b1);
			w = S_AXI_WVALID && (S_AXI_WREADY === 1'b1);
			b = (S_AXI_BVALID === 1'b1);
			r = S_AXI_BRESP;
			@(posedge CLK);
			if (aw) S_AXI_AWVALID <= 1'b0;
			if (w) S_AXI_WVALID <= 1'b0;
			if (b) S_AXI_BREADY <= 1'b0;
			n++;
		end
		check("write answer", 32'h1, {31'h0, b});
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit ar, v;
		int n;
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		ar = 0; v = 0; n = 0;
		while (!v && n < 200) begin
			@(negedge CLK);
			v = ar && (S_AXI_RVALID === 1'b1);
			d = S_AXI_RDATA;
			r = S_AXI_RRESP;
			if (S_AXI_ARREADY === 1'b1) ar = 1;
			@(posedge CLK);
			if (ar) S_AXI_ARVALID <= 1'b0;
			if (v) S_AXI_RREADY <= 1'b0;
			n++;
		end
		check("read answer", 32'h1, {31'h0, v});
	endtask

	task automatic expect_reg(input string name, input logic [7:0] a,
		input logic [31:0] exp);
		axi_read(a, rd, rr);
		check(name, exp, rd);
	endtask

	task automatic ctl_write(input logic [31:0] d);
		axi_write(wdc_pkg::OFF_CONTROL, 32'h01, rr);
		axi_write(wdc_pkg::OFF_CONTROL, d, rr);
	endtask

	task automatic wait_slow(input int n);
		repeat (n) @(posedge CLK);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_reset_map();
		expect_reg("control", wdc_pkg::OFF_CONTROL, 32'h72);
		expect_reg("irq status", wdc_pkg::OFF_IRQ_STAT, 32'h0);
		expect_reg("irq mask", wdc_pkg::OFF_IRQ_MASK, 32'h0);
		axi_read(8'h10, rd, rr);
		check("unmapped rresp", {30'h0, wdc_pkg::RESP_SLVERR}, {30'h0, rr});
		axi_write(8'h10, 32'hff, rr);
		check("unmapped bresp", {30'h0, wdc_pkg::RESP_SLVERR}, {30'h0, rr});
	endtask

	task automatic test_lock();
		axi_write(wdc_pkg::OFF_CONTROL, 32'h08, rr);
		expect_reg("locked control", wdc_pkg::OFF_CONTROL, 32'h72);
		axi_write(wdc_pkg::OFF_CONTROL, 32'h01, rr);
		axi_write(wdc_pkg::OFF_IRQ_MASK, 32'h03, rr);
		axi_write(wdc_pkg::OFF_CONTROL, 32'h0a, rr);
		expect_reg("expired unlock", wdc_pkg::OFF_CONTROL, 32'h72);
		expect_reg("refused flag", wdc_pkg::OFF_IRQ_STAT, 32'h2);
		check("irq raised", 32'h1, {31'h0, DOG_IRQ});
		axi_write(wdc_pkg::OFF_IRQ_STAT, 32'h2, rr);
		wait_slow(2);
		check("irq cleared", 32'h0, {31'h0, DOG_IRQ});
	endtask

	task automatic test_irq_timeout();
		int n;
		ctl_write(32'h0a);
		expect_reg("unlocked control", wdc_pkg::OFF_CONTROL, 32'h0a);
		wait_slow(2400);
		ctl_write(32'h0a);
		axi_read(wdc_pkg::OFF_COUNT, rd, rr);
		check("kick clears", 32'h1, {31'h0, rd < 32'h10});
		n = 0;
		while (DOG_IRQ !== 1'b1 && n < 6000) begin
			@(negedge CLK);
			n++;
		end
		check("no early timeout", 32'h1, {31'h0, n > 3000});
		check("irq timeout", 32'h1, {31'h0, DOG_IRQ});
		check("no reset", 32'h0, resets);
		expect_reg("status set", wdc_pkg::OFF_CONTROL, 32'h0e);
		expect_reg("irq bit", wdc_pkg::OFF_IRQ_STAT, 32'h1);
		axi_write(wdc_pkg::OFF_IRQ_STAT, 32'h1, rr);
	endtask

	task automatic test_reset_timeout();
		int n;
		ctl_write(32'h06);
		n = 0;
		while (resets == 0 && n < 6000) begin
			@(negedge CLK);
			n++;
		end
		check("reset pulses", 32'h1, resets);
		expect_reg("status kept", wdc_pkg::OFF_CONTROL, 32'h04);
		ctl_write(32'h00);
		expect_reg("status zeroed", wdc_pkg::OFF_CONTROL, 32'h00);
		ctl_write(32'h72);
		expect_reg("re enabled", wdc_pkg::OFF_CONTROL, 32'h72);
		ctl_write(32'h70);
		expect_reg("zero disables", wdc_pkg::OFF_CONTROL, 32'h70);
	endtask

	task automatic test_events();
		ctl_write(32'h72);
		SUPPLY_IRQ_IN <= 1'b1;
		wait_slow(6);
		SUPPLY_IRQ_IN <= 1'b0;
		expect_reg("supply event", wdc_pkg::OFF_CONTROL, 32'h70);
		ctl_write(32'h72);
		LOCK_IRQ_IN <= 1'b1;
		wait_slow(6);
		LOCK_IRQ_IN <= 1'b0;
		expect_reg("lock event", wdc_pkg::OFF_CONTROL, 32'h70);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		RESETN = 1'b0;
		SUPPLY_IRQ_IN = 1'b0;
		LOCK_IRQ_IN = 1'b0;
		S_AXI_AWADDR = 8'h00;
		S_AXI_ARADDR = 8'h00;
		S_AXI_WDATA = 32'h0;
		S_AXI_WSTRB = 4'hf;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'h0;
		{S_AXI_ARVALID, S_AXI_RREADY} = 2'h0;
		fails = 0;
		comparisons = 0;
		cycles = 0;
		resets = 0;
		repeat (2) @(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		test_reset_map();
		test_lock();
		test_irq_timeout();
		test_reset_timeout();
		test_events();
		print_verdict();
	end
endmodule
`default_nettype wire
